/* device_status_and_checksum_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "status_checksum_consts.svh"

module device_status_and_checksum_regs
  import status_checksum_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic sleep_or_shutdown,
  input wire logic active_mode,
  input wire logic [`CHANNEL_COUNT-1:0] channel_on,
  input wire logic pll_enabled,
  input wire logic mic_bias_enabled,
  output logic [7:0] rdata,
  output logic rd_valid,
  output logic [7:0] page_sel,
  output logic [7:0] device_status_one,
  output logic [7:0] transaction_checksum
);

  // ==========================================================
  // mode decode
  function automatic operating_mode_code_t decode_mode(input logic sleeping,
                                                       input logic active,
                                                       input logic [`CHANNEL_COUNT-1:0] on);
    if (sleeping || !active) begin
      // sleep or software shutdown wins over channel activity
      decode_mode = MODE_SLEEP;
    end else if (|on) begin
      // any record or playback channel on
      decode_mode = MODE_RUN;
    end else begin
      // active with every channel off
      decode_mode = MODE_IDLE;
    end
  endfunction : decode_mode

  // ==========================================================
  // address decode
  function automatic logic hits(input logic [7:0] page,
                                input logic [7:0] a,
                                input logic [7:0] off);
    // status and checksum live on the home page only
    hits = (page == `HOME_PAGE) && (a == off);
  endfunction : hits

  function automatic logic is_page_sel(input logic [7:0] a);
    // the page register answers on every page
    is_page_sel = (a == `PAGE_SEL_OFFSET);
  endfunction : is_page_sel

  // ==========================================================
  // checksum arithmetic
  function automatic logic [7:0] cksum_add(input logic [7:0] sum,
                                           input logic [7:0] data);
    logic [8:0] wide;
    wide = {1'b0, sum} + {1'b0, data};
    // carry out is dropped: modulo-256 running sum
    cksum_add = wide[7:0];
  endfunction : cksum_add

  // ==========================================================
  // register state
  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] checksum_reg;
  logic [7:0] checksum_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;

  // ==========================================================
  // decode helpers
  logic cksum_hit;
  logic status_hit;
  logic page_hit;
  operating_mode_code_t mode_code;

  // ==========================================================
  // access decode
  always_comb begin
    page_hit = is_page_sel(addr);
    status_hit = hits(page_reg, addr, `DEVICE_STATUS_ONE_OFFSET);
    cksum_hit = hits(page_reg, addr, `TRANSACTION_CHECKSUM_OFFSET);
  end

  // ==========================================================
  // page select
  always_comb begin
    page_next = page_reg;
    if (wr_en && page_hit) begin
      // any page from 0 to 255 may be chosen
      page_next = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= `PAGE_RESET;
    end else begin
      page_reg <= page_next;
    end
  end

  // ==========================================================
  // status register
  always_comb begin
    mode_code = decode_mode(sleep_or_shutdown, active_mode, channel_on);
    status_next = `STATUS_RESET;
    // live state only, host writes never reach this register
    status_next[`MODE_MSB:`MODE_LSB] = mode_code;
    status_next[`LOOP_CLOCK_BIT] = pll_enabled;
    status_next[`MIC_BIAS_BIT] = mic_bias_enabled;
    status_next[`MIC_BIAS_BIT-1:0] = `STATUS_RSVD;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==========================================================
  // transaction checksum
  always_comb begin
    checksum_next = checksum_reg;
    if (wr_en) begin
      if (cksum_hit) begin
        // a host write presets the running sum
        checksum_next = wdata;
      end else begin
        // every other write counts, page writes and other pages too
        checksum_next = cksum_add(checksum_reg, wdata);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      checksum_reg <= `CHECKSUM_RESET;
    end else begin
      checksum_reg <= checksum_next;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    rd_valid_next = rd_en;
    // read data holds until the next read
    rdata_next = rdata_reg;
    if (rd_en) begin
      if (page_hit) begin
        rdata_next = page_reg;
      end else if (status_hit) begin
        rdata_next = status_reg;
      end else if (cksum_hit) begin
        // a read in the same cycle as a write sees the old sum
        rdata_next = checksum_reg;
      end else begin
        rdata_next = `READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `READ_UNMAPPED;
      rd_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ==========================================================
  // outputs
  // every output is a register, no logic after the flops
  assign rdata = rdata_reg;
  assign rd_valid = rd_valid_reg;
  assign page_sel = page_reg;
  assign device_status_one = status_reg;
  assign transaction_checksum = checksum_reg;

endmodule : device_status_and_checksum_regs
`default_nettype wire

/* status_checksum_consts.svh */
// Operation
// - Status bits 7 to 5 hold a read-only operating-mode code that resets to 4, with codes 0 to 3 and 5 unused.
// - The mode code reads 4 while the device sleeps or is shut down by software.
// - The mode code reads 6 while the device is active with every record and playback channel off.
// - The mode code reads 7 while the device is active with at least one record or playback channel on.
// - Status bit 4 follows the loop clock enable and resets to 0.
// - Status bit 3 follows the microphone bias supply enable and resets to 0.
// - Status bits 2 to 0 read as 0, and the host writes only 0 to them.
// - A read of the checksum register returns the current checksum.
// - A host write to the checksum register loads the written byte as the new checksum.
// - Every write to any other register, on any page, updates the checksum.
// - The checksum resets to 0x00 and the status register to 0x80.
// - A page-select byte at offset 0 picks any page from 0 to 255 for later accesses.
`ifndef STATUS_CHECKSUM_CONSTS_SVH
`define STATUS_CHECKSUM_CONSTS_SVH

`define PAGE_SEL_OFFSET 8'h00
`define HOME_PAGE 8'h00
`define DEVICE_STATUS_ONE_OFFSET 8'h7A
`define TRANSACTION_CHECKSUM_OFFSET 8'h7E
`define PAGE_RESET 8'h00
`define STATUS_RESET 8'h80
`define CHECKSUM_RESET 8'h00
`define READ_UNMAPPED 8'h00
`define MODE_MSB 7
`define MODE_LSB 5
`define LOOP_CLOCK_BIT 4
`define MIC_BIAS_BIT 3
`define STATUS_RSVD 3'h0
`define CHANNEL_COUNT 8

`endif

/* status_checksum_pkg.sv */
`default_nettype none
package status_checksum_pkg;
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h4,
    MODE_IDLE = 3'h6,
    MODE_RUN = 3'h7
  } operating_mode_code_t;
endpackage : status_checksum_pkg
`default_nettype wire

/* status_checksum_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module status_checksum_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic sleep_or_shutdown,
  input wire logic active_mode,
  input wire logic pll_enabled,
  input wire logic mic_bias_enabled,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] channel_on,
  input wire logic [7:0] rdata,
  input wire logic [7:0] page_sel,
  input wire logic [7:0] device_status_one,
  input wire logic [7:0] transaction_checksum,
  input wire logic rd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ck_hit = page_sel == 8'h00 && addr == 8'h7E;
  wire logic [2:0] mode_exp = (sleep_or_shutdown || !active_mode) ? 3'h4 : (|channel_on ? 3'h7 : 3'h6);
  chk_mode_code: assert property ($past(rst_n) |-> device_status_one[7:5] == $past(mode_exp)) else $error("mode");
  chk_loop_flag: assert property ($past(rst_n) |-> device_status_one[4] == $past(pll_enabled)) else $error("loop");
  chk_bias_flag: assert property ($past(rst_n) |-> device_status_one[3] == $past(mic_bias_enabled)) else $error("bias");
  chk_rsvd_zero: assert property (device_status_one[2:0] == 3'h0) else $error("rsvd");
  chk_read_cksum: assert property (rd_en && ck_hit |=> rd_valid && rdata == $past(transaction_checksum)) else $error("rd");
  chk_cksum_load: assert property (wr_en && ck_hit |=> transaction_checksum == $past(wdata)) else $error("load");
  chk_cksum_sum: assert property (wr_en && !ck_hit |=> transaction_checksum == 8'($past(transaction_checksum) + $past(wdata))) else $error("sum");
  chk_page_pick: assert property (wr_en && addr == 8'h00 |=> page_sel == $past(wdata)) else $error("page");
  chk_status_ignore: assert property (wr_en && addr == 8'h7A && page_sel == 8'h00 |=> device_status_one == {$past(mode_exp), $past(pll_enabled), $past(mic_bias_enabled), 3'h0}) else $error("status wr");
  chk_valid_pulse: assert property (!rd_en |=> !rd_valid) else $error("valid");
  cover property (wr_en && ck_hit);
  cover property (rd_en && ck_hit);
  cover property (device_status_one[7:5] == 3'h7);
endmodule : status_checksum_asserts
bind device_status_and_checksum_regs status_checksum_asserts i_chk (.*);
`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rdata,
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [7:0] addr = 8'h00,
  output logic [7:0] wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk); addr = a; wdata = a == 8'h7A ? d & 8'hF8 : d; wr_en = 1;
    @(negedge clk); wr_en = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(negedge clk); addr = a; rd_en = 1;
    @(negedge clk); rd_en = 0; v = rd_valid; q = rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* device_status_and_checksum_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module device_status_and_checksum_regs_tb;
  import status_checksum_pkg::*;
  logic clk = 0, rst_n = 0, sleep_or_shutdown = 1, active_mode = 0, pll_enabled = 0, mic_bias_enabled = 0, v;
  logic wr_en, rd_en, rd_valid;
  logic [7:0] channel_on = 8'h00, addr, wdata, rdata, page_sel, device_status_one, transaction_checksum, d, e;
  logic [19:0] tab [4] = '{20'hEFF90, 20'h500C8, 20'h780F8, 20'h00180};
  int n_fail = 0, total_checks = 0;
  device_status_and_checksum_regs i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wdata(wdata),
    .sleep_or_shutdown(sleep_or_shutdown),
    .active_mode(active_mode),
    .channel_on(channel_on),
    .pll_enabled(pll_enabled),
    .mic_bias_enabled(mic_bias_enabled),
    .rdata(rdata),
    .rd_valid(rd_valid),
    .page_sel(page_sel),
    .device_status_one(device_status_one),
    .transaction_checksum(transaction_checksum)
  );
  host_model i_host (
    .clk(clk),
    .rd_valid(rd_valid),
    .rdata(rdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wdata(wdata)
  );
  initial forever #50 clk = ~clk;
  task automatic check(input string n, input logic [7:0] s, x);
    total_checks++;
    if (s !== x) begin n_fail++; $display("[ERR] %s exp %h got %h", n, x, s); end
  endtask : check
  task automatic results;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic t_reset;
    repeat (6) @(negedge clk);
    check("status", device_status_one, 8'h80);
    check("cksum", transaction_checksum, 8'h00);
    check("page rst", page_sel, 8'h00);
    check("valid rst", {7'h00, rd_valid}, 8'h00);
    rst_n = 1; $display("reset done");
  endtask : t_reset
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      {sleep_or_shutdown, active_mode, pll_enabled, mic_bias_enabled, channel_on, e} = tab[i];
      i_host.wr(8'h7A, 8'hFF);
      check("status", device_status_one, e);
      i_host.rd(8'h7A, d, v);
      check("status rd", d, e);
    end
    $display("status done");
  endtask : t_status
  task automatic t_cksum;
    i_host.wr(8'h7E, 8'h10); i_host.wr(8'h05, 8'hF5); i_host.wr(8'h05, 8'h20);
    i_host.rd(8'h7E, d, v); check("sum", d, 8'h25);
    check("valid", {7'h00, v}, 8'h01);
    i_host.wr(8'h00, 8'h01); check("page", page_sel, 8'h01);
    i_host.wr(8'h7E, 8'h03); i_host.rd(8'h7E, d, v); check("other page", d, 8'h00);
    i_host.wr(8'h00, 8'h00); i_host.rd(8'h7E, d, v); check("all pages", d, 8'h29);
    i_host.rd(8'h05, d, v); check("unmapped", d, 8'h00);
    $display("checksum done");
  endtask : t_cksum
  initial begin t_reset; t_status; t_cksum; results; end
endmodule : device_status_and_checksum_regs_tb
`default_nettype wire
